// [rtl/scx_params.svh]
// Constants for the stack and on-chip xdata configuration block
`ifndef SCX_PARAMS_SVH
`define SCX_PARAMS_SVH

// Special-function addresses
`define SCX_ADDR_CFG     8'hAF
`define SCX_ADDR_SPL     8'h81
`define SCX_ADDR_SPH     8'hB7

// Reset values
`define SCX_CFG_RST      8'h00
`define SCX_SPL_RST      8'h07
`define SCX_SPH_RST      3'h0

// Field positions in the configuration register
`define SCX_BIT_EXT      7
`define SCX_BIT_MAP      0

// Widths
`define SCX_SPH_W        3
`define SCX_SP_W         11
`define SCX_ONCHIP_AW    11
`define SCX_XDATA_AW     24

`endif

// [rtl/scx_pkg.sv]
// Types shared by the stack and on-chip xdata configuration block
package scx_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} scx_sfr_req_t;

	typedef struct packed {
		logic       push;
		logic       pop;
	} scx_stack_op_t;

	typedef enum logic [1:0] {
		SCX_SEL_NONE,
		SCX_SEL_CFG,
		SCX_SEL_SPL,
		SCX_SEL_SPH
	} scx_sel_t;

endpackage

// [rtl/scx_config.sv]
// Stack pointer and on-chip xdata mapping configuration register bank
`timescale 1ns/1ps
`include "scx_params.svh"

module scx_config #(
	parameter int XA_W      = `SCX_XDATA_AW,
	parameter int ONCHIP_AW = `SCX_ONCHIP_AW
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// Special-function register port
	input  wire scx_pkg::scx_sfr_req_t     sfr_req,
	output logic [7:0]                     sfr_rdata,
	output logic                           sfr_rd_valid,
	// Stack operations from the core
	input  wire scx_pkg::scx_stack_op_t    stack_op,
	output logic [`SCX_SP_W-1:0]           stack_addr,
	// External data address decode
	input  wire logic                      xdata_req,
	input  wire logic [XA_W-1:0]           xdata_addr,
	output logic                           xdata_onchip,
	output logic                           xdata_external,
	// Configuration state
	output logic                           stack_extend_enable,
	output logic                           internal_xdata_map_enable
);

	////////////////////////////////////////////////////////////////////////////
	// State

	localparam logic [7:0]     CFG_RST = `SCX_CFG_RST;

	logic                      ext_r;
	logic                      map_r;
	logic [7:0]                spl_r;
	logic [`SCX_SPH_W-1:0]     sph_r;
	logic                      ext_nxt;
	logic                      map_nxt;
	logic [7:0]                spl_nxt;
	logic [`SCX_SPH_W-1:0]     sph_nxt;
	logic [7:0]                rdata_nxt;
	logic                      onchip_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	scx_pkg::scx_sel_t         sel;
	wire                       hit_cfg = sfr_req.addr == `SCX_ADDR_CFG;
	wire                       hit_spl = sfr_req.addr == `SCX_ADDR_SPL;
	wire                       hit_sph = sfr_req.addr == `SCX_ADDR_SPH;

	assign sel = hit_cfg ? scx_pkg::SCX_SEL_CFG :
	             hit_spl ? scx_pkg::SCX_SEL_SPL :
	             hit_sph ? scx_pkg::SCX_SEL_SPH : scx_pkg::SCX_SEL_NONE;

	wire                       wr_cfg = sfr_req.wr && sel == scx_pkg::SCX_SEL_CFG;
	wire                       wr_spl = sfr_req.wr && sel == scx_pkg::SCX_SEL_SPL;
	// High byte only writable with the extend bit set
	wire                       wr_sph = sfr_req.wr && sel == scx_pkg::SCX_SEL_SPH
	                                    && ext_r;

	////////////////////////////////////////////////////////////////////////////
	// Stack pointer arithmetic

	wire [`SCX_SP_W-1:0]       sp_full = {sph_r, spl_r};
	wire [`SCX_SP_W-1:0]       sp_inc  = sp_full + `SCX_SP_W'(1);
	wire [`SCX_SP_W-1:0]       sp_dec  = sp_full - `SCX_SP_W'(1);
	wire [7:0]                 spl_inc = spl_r + 8'h01;
	wire [7:0]                 spl_dec = spl_r - 8'h01;
	wire                       do_push = stack_op.push && !stack_op.pop;
	wire                       do_pop  = stack_op.pop && !stack_op.push;

	// Configuration: only bits 7 and 0 are stored
	assign ext_nxt = wr_cfg ? sfr_req.wdata[`SCX_BIT_EXT] : ext_r;
	assign map_nxt = wr_cfg ? sfr_req.wdata[`SCX_BIT_MAP] : map_r;

	// Register write wins over a stack operation in the same cycle
	assign spl_nxt = wr_spl            ? sfr_req.wdata :
	                 do_push && ext_r  ? sp_inc[7:0] :
	                 do_push           ? spl_inc :
	                 do_pop && ext_r   ? sp_dec[7:0] :
	                 do_pop            ? spl_dec : spl_r;

	assign sph_nxt = wr_sph            ? sfr_req.wdata[`SCX_SPH_W-1:0] :
	                 do_push && ext_r  ? sp_inc[`SCX_SP_W-1:8] :
	                 do_pop && ext_r   ? sp_dec[`SCX_SP_W-1:8] : sph_r;

	////////////////////////////////////////////////////////////////////////////
	// Read data

	always_comb begin
		case (sel)
			scx_pkg::SCX_SEL_CFG: begin
				rdata_nxt = {ext_r, 6'h00, map_r};
			end
			scx_pkg::SCX_SEL_SPL: begin
				rdata_nxt = spl_r;
			end
			scx_pkg::SCX_SEL_SPH: begin
				rdata_nxt = ext_r ? {5'h00, sph_r} : 8'h00;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Xdata decode

	wire                       low_window = xdata_addr[XA_W-1:ONCHIP_AW] == '0;
	// Map bit clear sends every access off chip
	assign onchip_nxt = xdata_req && map_r && low_window;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_r <= CFG_RST[`SCX_BIT_EXT];
			map_r <= CFG_RST[`SCX_BIT_MAP];
			spl_r <= `SCX_SPL_RST;
			sph_r <= `SCX_SPH_RST;
		end else begin
			ext_r <= ext_nxt;
			map_r <= map_nxt;
			spl_r <= spl_nxt;
			sph_r <= sph_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sfr_rdata                 <= 8'h00;
			sfr_rd_valid              <= 1'b0;
			xdata_onchip              <= 1'b0;
			xdata_external            <= 1'b0;
			stack_extend_enable       <= 1'b0;
			internal_xdata_map_enable <= 1'b0;
			stack_addr                <= {3'h0, `SCX_SPL_RST};
		end else begin
			sfr_rdata                 <= sfr_req.rd ? rdata_nxt : 8'h00;
			sfr_rd_valid              <= sfr_req.rd;
			xdata_onchip              <= onchip_nxt;
			xdata_external            <= xdata_req && !onchip_nxt;
			stack_extend_enable       <= ext_nxt;
			internal_xdata_map_enable <= map_nxt;
			// Pre-incremented pointer is the push store address
			stack_addr                <= ext_nxt ? {sph_nxt, spl_nxt} :
			                                       {3'h0, spl_nxt};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	wire quiet = !sfr_req.wr;

	AST_CFG_RESET: assert property ($past(reset) |-> !ext_r && !map_r)
		else $error("config not cleared by reset");
	AST_SP_RESET: assert property ($past(reset) |-> stack_addr == 11'h007)
		else $error("stack pointer not 07H after reset");
	AST_FIRST_PUSH: assert property ($past(reset) && do_push && quiet
		|=> stack_addr == 11'h008)
		else $error("first push not at 08H");
	AST_CARRY: assert property (ext_r && do_push && quiet && sp_full == 11'h0FF
		|=> stack_addr == 11'h100 && sph_r == 3'h1)
		else $error("extended stack did not carry");
	AST_WRAP: assert property (!ext_r && do_push && quiet && spl_r == 8'hFF
		|=> spl_r == 8'h00 && $stable(sph_r) && stack_addr == 11'h000)
		else $error("plain stack did not wrap");
	AST_SPH_LOCK: assert property (!ext_r && sfr_req.wr && hit_sph
		|=> $stable(sph_r))
		else $error("locked high byte was written");
	AST_SPH_HIDE: assert property (!ext_r && sfr_req.rd && hit_sph
		|=> sfr_rd_valid && sfr_rdata == 8'h00)
		else $error("locked high byte was readable");
	AST_SPH_READ: assert property (ext_r && sfr_req.rd && hit_sph
		|=> sfr_rdata == {5'h00, $past(sph_r)})
		else $error("high byte read wrong");
	AST_CFG_IGNORE: assert property (sfr_req.wr && hit_cfg
		|=> ##1 sfr_req.rd && hit_cfg |=> sfr_rdata[6:1] == 6'h00)
		else $error("unused config bits not zero");
	AST_ONCHIP: assert property (xdata_req && map_r && low_window
		|=> xdata_onchip && !xdata_external)
		else $error("low window not on chip");
	AST_OFFCHIP: assert property (xdata_req && !map_r
		|=> xdata_external && !xdata_onchip)
		else $error("unmapped access not external");

	COV_CARRY: cover property (ext_r && do_push && sp_full == 11'h0FF);
	COV_WRAP: cover property (!ext_r && do_push && spl_r == 8'hFF);
	COV_ONCHIP: cover property (xdata_req && map_r && low_window);
	COV_SPH_WR: cover property (ext_r && wr_sph);

endmodule

// [testbench/scx_config_tb.sv]
// Self-checking bench for the stack and on-chip xdata configuration block
`timescale 1ns/1ps
`include "scx_params.svh"

module scx_config_tb;

	logic                  clk;
	logic                  reset;
	scx_pkg::scx_sfr_req_t sfr_req;
	logic [7:0]            sfr_rdata;
	logic                  sfr_rd_valid;
	scx_pkg::scx_stack_op_t stack_op;
	logic [10:0]           stack_addr;
	logic                  xdata_req;
	logic [23:0]           xdata_addr;
	logic                  xdata_onchip;
	logic                  xdata_external;
	logic                  stack_extend_enable;
	logic                  internal_xdata_map_enable;
	int                    fail_count;
	int                    n_compared;

	scx_config i_dut (
		.clk                       (clk),
		.reset                     (reset),
		.sfr_req                   (sfr_req),
		.sfr_rdata                 (sfr_rdata),
		.sfr_rd_valid              (sfr_rd_valid),
		.stack_op                  (stack_op),
		.stack_addr                (stack_addr),
		.xdata_req                 (xdata_req),
		.xdata_addr                (xdata_addr),
		.xdata_onchip              (xdata_onchip),
		.xdata_external            (xdata_external),
		.stack_extend_enable       (stack_extend_enable),
		.internal_xdata_map_enable (internal_xdata_map_enable)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req = '{a, 1'b1, 1'b0, d};
		@(posedge clk);
		#1;
		sfr_req.wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_req = '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clk);
		#1;
		sfr_req.rd = 1'b0;
		chk("sfr_rd_valid", 11'h001, {10'h000, sfr_rd_valid});
		chk("sfr_rdata", {3'h0, e}, {3'h0, sfr_rdata});
		@(posedge clk);
		#1;
	endtask

	task automatic push(input logic [10:0] e);
		stack_op = '{1'b1, 1'b0};
		@(posedge clk);
		#1;
		stack_op = '0;
		chk("stack_addr", e, stack_addr);
		@(posedge clk);
		#1;
	endtask

	task automatic pop(input logic [10:0] e);
		stack_op = '{1'b0, 1'b1};
		@(posedge clk);
		#1;
		stack_op = '0;
		chk("stack_addr", e, stack_addr);
		@(posedge clk);
		#1;
	endtask

	task automatic xd(input logic [23:0] a, input logic on);
		xdata_req  = 1'b1;
		xdata_addr = a;
		@(posedge clk);
		#1;
		xdata_req = 1'b0;
		chk("xdata_onchip", {10'h000, on}, {10'h000, xdata_onchip});
		chk("xdata_external", {10'h000, ~on}, {10'h000, xdata_external});
		@(posedge clk);
		#1;
	endtask

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (2000) @(posedge clk);
		fail_count++;
		summarize();
	end

	initial begin
		fail_count = 0;
		n_compared = 0;
		reset      = 1'b1;
		sfr_req    = '0;
		stack_op   = '0;
		xdata_req  = 1'b0;
		xdata_addr = 24'h000000;
		repeat (3) @(posedge clk);
		#1;
		reset = 1'b0;
		chk("stack_addr", 11'h007, stack_addr);
		chk("config bits", 11'h000, {9'h000, stack_extend_enable, internal_xdata_map_enable});
		rd(`SCX_ADDR_CFG, 8'h00);
		rd(`SCX_ADDR_SPL, 8'h07);
		push(11'h008);
		wr(`SCX_ADDR_SPH, 8'h05);
		rd(`SCX_ADDR_SPH, 8'h00);
		wr(`SCX_ADDR_CFG, 8'h7E);
		rd(`SCX_ADDR_CFG, 8'h00);
		wr(`SCX_ADDR_SPL, 8'hFF);
		push(11'h000);
		wr(`SCX_ADDR_CFG, 8'hFF);
		rd(`SCX_ADDR_CFG, 8'h81);
		chk("config bits", 11'h003, {9'h000, stack_extend_enable, internal_xdata_map_enable});
		rd(`SCX_ADDR_SPH, 8'h00);
		wr(`SCX_ADDR_SPH, 8'hFD);
		rd(`SCX_ADDR_SPH, 8'h05);
		wr(`SCX_ADDR_SPL, 8'hFF);
		chk("stack_addr", 11'h5FF, stack_addr);
		push(11'h600);
		pop(11'h5FF);
		xd(24'h0007FF, 1'b1);
		xd(24'h000800, 1'b0);
		wr(`SCX_ADDR_CFG, 8'h80);
		xd(24'h000000, 1'b0);
		summarize();
	end

endmodule
